// *** hw/rx_recovery_consts.svh ***
// Timing positions and counts for receive data recovery
`ifndef RX_RECOVERY_CONSTS_SVH
`define RX_RECOVERY_CONSTS_SVH
`define OVERSAMPLE_RATE 5'h10
`define TICK_FIRST 5'h01
`define TICK_START_A 5'h03
`define TICK_START_B 5'h05
`define TICK_START_C 5'h07
`define TICK_VOTE_A 5'h08
`define TICK_VOTE_B 5'h09
`define TICK_VOTE_C 5'h0a
`define TICK_LAST 5'h10
`define TICK_RESYNC_MAX 5'h0f
`define EDGE_SAT 5'h1f
`define BITS_SHORT 4'h8
`define BITS_LONG 4'h9
`define IDLE_SHORT 4'ha
`define IDLE_LONG 4'hb
`define HIST_IDLE 3'h7
`define DIV_MIN 16'h0002
`endif

// *** hw/rx_recovery_pkg.sv ***
// Types for receive data recovery
package rx_recovery_pkg;
  typedef enum logic [1:0] {st_hunt, st_start, st_data, st_stop} rx_state_t;
endpackage

// *** hw/tick_divider.sv ***
// Divides the module clock down to a one-cycle oversample enable
`timescale 1ns/1ps
`include "rx_recovery_consts.svh"
module tick_divider #(
  parameter int WIDTH = 16
) (
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  input wire logic run_in,
  input wire logic [WIDTH-1:0] div_in,
  output logic tick_out
);
  logic [WIDTH-1:0] count;
  logic [WIDTH-1:0] next_count;
  logic next_tick;

  if (WIDTH < 2) begin : g_chk
    $error("tick_divider WIDTH must be at least 2");
  end

  always_comb begin
    next_count = count + {{(WIDTH-1){1'b0}}, 1'b1};
    next_tick = 1'b0;
    // Divisors below two are treated as two
    if (!run_in) begin
      next_count = '0;
    end else if (next_count >= div_in && next_count >= WIDTH'(`DIV_MIN)) begin
      next_count = '0;
      next_tick = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      count <= '0;
      tick_out <= 1'b0;
    end else begin
      count <= next_count;
      tick_out <= next_tick;
    end
  end
endmodule

// *** hw/majority_vote.sv ***
// Three-sample majority vote with disagreement detect
`timescale 1ns/1ps
module majority_vote (
  input wire logic [2:0] samples_in,
  output logic value_out,
  output logic disagree_out
);
  assign value_out = (samples_in[0] & samples_in[1]) | (samples_in[0] & samples_in[2])
                   | (samples_in[1] & samples_in[2]);
  assign disagree_out = (|samples_in) & ~(&samples_in);
endmodule

// *** hw/uart_rx_recovery.sv ***
// Receive data recovery, error detection and standby wakeup
// Contract
// R01: Sample input on sixteen-times-baud oversample tick
// R02: Resync tick counter on start and 1-to-0
// R03: Start search: zero after three ones
// R04: Verify start at ticks 3,5,7, noise
// R05: Failed verification restarts search, counter reset
// R06: Data bit is majority of ticks 8-10
// R07: Late start samples never cancel, set noise
// R08: Stop majority zero gives framing error
// R09: Missing stop one, break included, frames error
// R10: Framing error with buffer full, same cycle
// R11: Standby suppresses reception and interrupt request
// R12: Address mark wakes and sets buffer full
// R13: Waking idle sets neither idle nor full
// R14: Idle type selects where ones counting begins
// R15: Software re-arms standby on address mismatch
// R16: Standby set on idle line wakes immediately
// R17: Length control selects eight or nine bits
// R18: Wake select one address, zero idle
// R19: Idle type one after stop, zero start
// R20: Idle after ten or eleven ones
// R21: Noise accumulated per character, reported at transfer
`timescale 1ns/1ps
`include "rx_recovery_consts.svh"
module uart_rx_recovery
  import rx_recovery_pkg::*;
#(
  parameter int DIV_WIDTH = 16
) (
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  input wire logic rxd_in,
  input wire logic enable_in,
  input wire logic [DIV_WIDTH-1:0] baud_div_in,
  input wire logic char9_in,
  input wire logic wake_addr_in,
  input wire logic idle_count_type_in,
  input wire logic standby_set_in,
  input wire logic flag_clear_in,
  output logic [8:0] rx_data_out,
  output logic rx_buffer_full_flag_out,
  output logic frame_error_flag_out,
  output logic noise_flag_out,
  output logic idle_flag_out,
  output logic rx_standby_bit_out,
  output logic rx_irq_out
);
  // Input synchroniser; only the second stage is read
  logic rxd_meta;
  logic samp;
  logic tick;
  rx_state_t state;
  rx_state_t next_state;
  logic [4:0] rt;
  logic [4:0] next_rt;
  logic [4:0] cur;
  logic [2:0] hist;
  logic [2:0] next_hist;
  logic [1:0] vs;
  logic [1:0] next_vs;
  logic [2:0] vote_in;
  logic vote_val;
  logic vote_dis;
  logic [8:0] shreg;
  logic [8:0] next_shreg;
  logic [3:0] bitcnt;
  logic [3:0] next_bitcnt;
  logic [3:0] nbits;
  logic [3:0] idle_target;
  logic prev_bit;
  logic next_prev_bit;
  logic last_samp;
  logic next_last_samp;
  logic [4:0] since_edge;
  logic [4:0] next_since_edge;
  logic noise_acc;
  logic next_noise_acc;
  logic [3:0] ones_tk;
  logic [3:0] next_ones_tk;
  logic [3:0] idle_bits;
  logic [3:0] next_idle_bits;
  logic idle_seen;
  logic next_idle_seen;
  logic [8:0] next_data;
  logic next_full;
  logic next_fe;
  logic next_nf;
  logic next_idle;
  logic next_standby;
  logic next_irq;
  logic done;
  logic idle_hit;

  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rxd_meta <= 1'b1;
      samp <= 1'b1;
    end else begin
      rxd_meta <= rxd_in;
      samp <= rxd_meta;
    end
  end

  // R01: sixteen-times-baud tick
  tick_divider #(
    .WIDTH(DIV_WIDTH)
  ) u_div (
    .ref_clk_in(ref_clk_in),
    .sys_rst_in(sys_rst_in),
    .run_in(enable_in),
    .div_in(baud_div_in),
    .tick_out(tick)
  );

  assign vote_in = {vs, samp};

  majority_vote u_vote (
    .samples_in(vote_in),
    .value_out(vote_val),
    .disagree_out(vote_dis)
  );

  // R17: eight or nine data bits
  assign nbits = char9_in ? `BITS_LONG : `BITS_SHORT;
  // R20: ten or eleven ones mean idle
  assign idle_target = char9_in ? `IDLE_LONG : `IDLE_SHORT;
  assign cur = rt + 5'h01;

  always_comb begin
    next_state = state;
    next_rt = rt;
    next_hist = hist;
    next_vs = vs;
    next_shreg = shreg;
    next_bitcnt = bitcnt;
    next_prev_bit = prev_bit;
    next_last_samp = last_samp;
    next_since_edge = since_edge;
    next_noise_acc = noise_acc;
    next_ones_tk = ones_tk;
    next_idle_bits = idle_bits;
    done = 1'b0;
    if (!enable_in) begin
      next_state = st_hunt;
      next_rt = '0;
      next_hist = '0;
      next_ones_tk = '0;
      next_idle_bits = '0;
    end else if (tick) begin
      case (state)
        st_hunt: begin
          next_hist = {hist[1:0], samp};
          // R03: zero after three ones
          if (hist == `HIST_IDLE && !samp) begin
            next_state = st_start;
            // R02: counter restarts on the start edge
            next_rt = `TICK_FIRST;
            next_noise_acc = 1'b0;
          end
          // R20: whole bit times of ones while hunting
          if (!samp) begin
            next_ones_tk = '0;
            next_idle_bits = '0;
          end else begin
            next_ones_tk = ones_tk + 4'h1;
            if (ones_tk == 4'hf && idle_bits != 4'hf) begin
              next_idle_bits = idle_bits + 4'h1;
            end
          end
        end
        st_start: begin
          next_rt = cur;
          if (cur == `TICK_START_A || cur == `TICK_START_B) begin
            next_vs = {vs[0], samp};
          end
          if (cur == `TICK_START_C) begin
            // R05: failed verification restarts the search
            if (vote_val) begin
              next_state = st_hunt;
              next_rt = '0;
              next_hist = '0;
            end else begin
              // R04: two zeros accept, disagreement is noise
              next_noise_acc = noise_acc | vote_dis;
            end
          end
          // R07: late ones only flag noise
          if (cur >= `TICK_VOTE_A && cur <= `TICK_VOTE_C && samp) begin
            next_noise_acc = 1'b1;
          end
          if (cur == `TICK_LAST) begin
            next_state = st_data;
            next_rt = '0;
            next_bitcnt = '0;
            next_prev_bit = 1'b0;
            next_last_samp = 1'b0;
            next_since_edge = `EDGE_SAT;
            // R14: idle type zero counts from after the start bit
            next_idle_bits = '0;
          end
        end
        default: begin
          next_rt = cur;
          next_last_samp = samp;
          if (last_samp && !samp) begin
            next_since_edge = `TICK_FIRST;
          end else if (since_edge != `EDGE_SAT) begin
            next_since_edge = since_edge + 5'h01;
          end
          if (cur == `TICK_VOTE_A || cur == `TICK_VOTE_B) begin
            next_vs = {vs[0], samp};
          end
          if (cur == `TICK_VOTE_C) begin
            // R06: majority of three, disagreement is noise
            next_noise_acc = noise_acc | vote_dis;
            // R19: type one counts only after the stop bit
            if (idle_count_type_in || !vote_val) begin
              next_idle_bits = '0;
            end else if (idle_bits != 4'hf) begin
              next_idle_bits = idle_bits + 4'h1;
            end
            if (state == st_data) begin
              next_shreg = {vote_val, shreg[8:1]};
              next_bitcnt = bitcnt + 4'h1;
              next_prev_bit = vote_val;
              // R02: realign to the edge of a 1-to-0 change
              if (prev_bit && !vote_val && since_edge < `TICK_RESYNC_MAX) begin
                next_rt = since_edge + 5'h01;
              end
            end else begin
              // R08: stop bit by majority
              done = 1'b1;
              next_state = st_hunt;
              next_rt = '0;
              next_hist = {3{vote_val}};
              next_ones_tk = '0;
            end
          end
          if (state == st_data && cur == `TICK_LAST) begin
            next_rt = '0;
            if (bitcnt == nbits) begin
              next_state = st_stop;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state <= st_hunt;
      rt <= '0;
      hist <= '0;
      vs <= '0;
      shreg <= '0;
      bitcnt <= '0;
      prev_bit <= 1'b0;
      last_samp <= 1'b0;
      since_edge <= '0;
      noise_acc <= 1'b0;
      ones_tk <= '0;
      idle_bits <= '0;
    end else begin
      state <= next_state;
      rt <= next_rt;
      hist <= next_hist;
      vs <= next_vs;
      shreg <= next_shreg;
      bitcnt <= next_bitcnt;
      prev_bit <= next_prev_bit;
      last_samp <= next_last_samp;
      since_edge <= next_since_edge;
      noise_acc <= next_noise_acc;
      ones_tk <= next_ones_tk;
      idle_bits <= next_idle_bits;
    end
  end

  // Level test so a line already idle counts at once
  assign idle_hit = enable_in && idle_bits >= idle_target;

  // Flags: a set in the clearing cycle wins over the clear
  always_comb begin
    next_data = rx_data_out;
    next_full = rx_buffer_full_flag_out & ~flag_clear_in;
    next_fe = frame_error_flag_out & ~flag_clear_in;
    next_nf = noise_flag_out & ~flag_clear_in;
    next_idle = idle_flag_out & ~flag_clear_in;
    next_standby = rx_standby_bit_out | standby_set_in;
    next_idle_seen = idle_seen & idle_hit;
    if (done) begin
      // R11: standby drops characters without an address mark
      // R12: address mark wakes and still transfers
      if (!rx_standby_bit_out || (wake_addr_in && shreg[8])) begin
        if (rx_standby_bit_out) begin
          next_standby = 1'b0;
        end
        next_data = char9_in ? shreg : {1'b0, shreg[8:1]};
        next_full = 1'b1;
        // R09: no one in the stop slot, break too
        // R10: error flag lands with buffer full
        next_fe = frame_error_flag_out & ~flag_clear_in | ~vote_val;
        // R21: whole-character noise reported here
        next_nf = next_nf | noise_acc | vote_dis;
      end
    end
    if (idle_hit && !idle_seen) begin
      next_idle_seen = 1'b1;
      if (rx_standby_bit_out && !wake_addr_in) begin
        // R13: waking idle raises no flag
        // R18: wake select zero, idle
        next_standby = 1'b0;
      end else if (!rx_standby_bit_out) begin
        next_idle = 1'b1;
      end
    end else if (idle_hit && rx_standby_bit_out && !wake_addr_in) begin
      // R16: standby set after idle wakes at once
      next_standby = 1'b0;
    end
    // R11: request held off in standby
    next_irq = (next_full | next_idle) & ~next_standby;
  end

  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rx_data_out <= '0;
      rx_buffer_full_flag_out <= 1'b0;
      frame_error_flag_out <= 1'b0;
      noise_flag_out <= 1'b0;
      idle_flag_out <= 1'b0;
      rx_standby_bit_out <= 1'b0;
      rx_irq_out <= 1'b0;
      idle_seen <= 1'b0;
    end else begin
      rx_data_out <= next_data;
      rx_buffer_full_flag_out <= next_full;
      frame_error_flag_out <= next_fe;
      noise_flag_out <= next_nf;
      idle_flag_out <= next_idle;
      rx_standby_bit_out <= next_standby;
      rx_irq_out <= next_irq;
      idle_seen <= next_idle_seen;
    end
  end
endmodule

// *** tb/uart_rx_recovery_checker.sv ***
// Port checker for receive data recovery
`timescale 1ns/1ps
module uart_rx_recovery_checker #(
  parameter int DIV_WIDTH = 16
) (
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  input wire logic rxd_in,
  input wire logic enable_in,
  input wire logic [DIV_WIDTH-1:0] baud_div_in,
  input wire logic char9_in,
  input wire logic wake_addr_in,
  input wire logic idle_count_type_in,
  input wire logic standby_set_in,
  input wire logic flag_clear_in,
  input wire logic [8:0] rx_data_out,
  input wire logic rx_buffer_full_flag_out,
  input wire logic frame_error_flag_out,
  input wire logic noise_flag_out,
  input wire logic idle_flag_out,
  input wire logic rx_standby_bit_out,
  input wire logic rx_irq_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (sys_rst_in);
  fe_with_full_a: assert property (
    $rose(frame_error_flag_out) |-> $rose(rx_buffer_full_flag_out))
    else $error("framing flag rose apart from full flag");
  nf_with_full_a: assert property (
    $rose(noise_flag_out) |-> $rose(rx_buffer_full_flag_out))
    else $error("noise flag rose apart from full flag");
  irq_mask_a: assert property (
    rx_irq_out == ((rx_buffer_full_flag_out | idle_flag_out) & !rx_standby_bit_out))
    else $error("request not masked by standby");
  full_hold_a: assert property (
    rx_buffer_full_flag_out && !flag_clear_in |=> rx_buffer_full_flag_out)
    else $error("full flag dropped without clear");
  standby_set_a: assert property (
    standby_set_in && wake_addr_in |=> rx_standby_bit_out)
    else $error("standby bit not set");
  addr_wake_a: assert property (
    $fell(rx_standby_bit_out) && wake_addr_in |->
      rx_buffer_full_flag_out && (char9_in ? rx_data_out[8] : rx_data_out[7]))
    else $error("address wake without full flag and mark");
  idle_wake_a: assert property (
    $fell(rx_standby_bit_out) && !wake_addr_in |->
      !$rose(rx_buffer_full_flag_out) && !$rose(idle_flag_out))
    else $error("waking idle raised a flag");
  short_msb_a: assert property (
    $rose(rx_buffer_full_flag_out) && !char9_in |-> rx_data_out[8] == 1'b0)
    else $error("ninth bit set in eight bit mode");
  cover property ($rose(frame_error_flag_out));
  cover property ($rose(noise_flag_out));
  cover property ($fell(rx_standby_bit_out));
endmodule

// *** tb/serial_tx_model.sv ***
// Behavioural remote serial transmitter
`timescale 1ns/1ps
module serial_tx_model #(
  parameter int BIT_CLKS = 64
) (
  input wire logic ref_clk_in,
  output logic line_out
);
  initial line_out = 1'b1;
  task automatic idle(input int bits);
    repeat (bits * BIT_CLKS) @(negedge ref_clk_in);
  endtask
  // Too short to pass start verification
  task automatic pulse(input int clks);
    line_out = 1'b0;
    repeat (clks) @(negedge ref_clk_in);
    line_out = 1'b1;
  endtask
  task automatic send(input logic [8:0] d, input int n, input logic stop, input int g);
    int b;
    int c;
    logic v;
    for (b = 0; b <= n + 1; b++) begin
      v = (b == 0) ? 1'b0 : (b == n + 1) ? stop : d[b-1];
      // One-tick glitch mid-bit, hits exactly one vote sample
      for (c = 0; c < BIT_CLKS; c++) begin
        line_out = (b == g && c >= 32 && c < 36) ? !v : v;
        @(negedge ref_clk_in);
      end
    end
    line_out = 1'b1;
  endtask
endmodule

// *** tb/uart_rx_data_recovery_wakeup_test.sv ***
// Self-checking bench for receive data recovery and wakeup
`timescale 1ns/1ps
module uart_rx_data_recovery_wakeup_test;
  logic ref_clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic rxd, enable, char9, wake_addr, ity;
  logic sset, fclr = 1'b0;
  logic [15:0] div;
  logic [8:0] rx_data;
  logic full, fe, nf, idle, sby, irq;
  logic [10:0] exp_q[$];
  logic [31:0] seed = 32'h0000_32ea;
  int n_mismatch = 0, checked = 0, cycles = 0, i;
  always #2 ref_clk_in = ~ref_clk_in;
  serial_tx_model #(.BIT_CLKS(64)) i_tx (.ref_clk_in(ref_clk_in), .line_out(rxd));
  uart_rx_recovery #(.DIV_WIDTH(16)) i_dut (.ref_clk_in(ref_clk_in),
    .sys_rst_in(sys_rst_in), .rxd_in(rxd), .enable_in(enable), .baud_div_in(div),
    .char9_in(char9), .wake_addr_in(wake_addr), .idle_count_type_in(ity),
    .standby_set_in(sset), .flag_clear_in(fclr), .rx_data_out(rx_data),
    .rx_buffer_full_flag_out(full), .frame_error_flag_out(fe), .noise_flag_out(nf),
    .idle_flag_out(idle), .rx_standby_bit_out(sby), .rx_irq_out(irq));
  function automatic logic [8:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[8:0];
  endfunction
  task stop_test;
    $display("Comparisons %0d, mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic check(input string what, input logic [10:0] e, input logic [10:0] s);
    checked++;
    if (s !== e) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, e, s);
    end
  endtask
  // Note the expected character, then send it
  task automatic frame(input logic [8:0] d, input logic stop, input int g, input logic n);
    exp_q.push_back({char9 ? d : {1'b0, d[7:0]}, !stop, n});
    i_tx.send(d, char9 ? 9 : 8, stop, g);
  endtask
  task automatic standby();
    sset = 1'b1;
    @(negedge ref_clk_in);
    sset = 1'b0;
  endtask
  // Flags are sticky, so clear after each character
  always @(negedge ref_clk_in) begin
    if (fclr) fclr <= 1'b0;
    else if (full === 1'b1) begin
      check("char", exp_q.size() > 0 ? exp_q.pop_front() : 11'h7ff, {rx_data, fe, nf});
      fclr <= 1'b1;
    end
  end
  always @(posedge ref_clk_in) begin
    cycles++;
    if (cycles == 90000) begin
      n_mismatch++;
      stop_test();
    end
  end
  initial begin
    enable = 1'b0;
    char9 = 1'b0;
    wake_addr = 1'b0;
    ity = 1'b0;
    sset = 1'b0;
    div = 16'h0004;
    repeat (16) @(posedge ref_clk_in);
    @(negedge ref_clk_in);
    sys_rst_in = 1'b0;
    enable = 1'b1;
    i_tx.idle(2);
    for (i = 0; i < 4; i++) frame(xs(), 1'b1, -1, 1'b0);
    char9 = 1'b1;
    for (i = 0; i < 3; i++) frame(xs(), 1'b1, -1, 1'b0);
    char9 = 1'b0;
    // All ones, so a glitch never triggers a resync
    frame(9'h0ff, 1'b1, 0, 1'b1);
    frame(9'h0ff, 1'b1, 4, 1'b1);
    frame(9'h0ff, 1'b1, 9, 1'b1);
    frame(9'h000, 1'b0, -1, 1'b0);
    i_tx.idle(1);
    frame(9'h0a5, 1'b0, -1, 1'b0);
    i_tx.idle(1);
    i_tx.pulse(8);
    i_tx.idle(1);
    frame(9'h03c, 1'b1, -1, 1'b0);
    wake_addr = 1'b1;
    standby();
    i_tx.send(9'h055, 8, 1'b1, -1);
    frame(9'h0c1, 1'b1, -1, 1'b0);
    check("standby", 11'h000, {10'h000, sby});
    standby();
    i_tx.send(9'h012, 8, 1'b1, -1);
    wake_addr = 1'b0;
    // Still in standby here, so an idle line must wake it first
    i_tx.idle(12);
    check("idle wake", 11'h000, {9'h000, idle, sby});
    for (i = 0; i < 2; i++) begin
      ity = i[0];
      frame(9'h0f0, 1'b1, -1, 1'b0);
      i_tx.idle(12);
      check("idle", 11'h001, {10'h000, idle});
    end
    frame(9'h033, 1'b1, -1, 1'b0);
    standby();
    i_tx.idle(12);
    check("idle wake", 11'h000, {9'h000, idle, sby});
    repeat (200) @(negedge ref_clk_in);
    check("left", 11'h000, 11'(exp_q.size()));
    stop_test();
  end
endmodule
bind uart_rx_recovery uart_rx_recovery_checker #(.DIV_WIDTH(DIV_WIDTH)) i_chk (
  .ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in), .rxd_in(rxd_in),
  .enable_in(enable_in), .baud_div_in(baud_div_in), .char9_in(char9_in),
  .wake_addr_in(wake_addr_in), .idle_count_type_in(idle_count_type_in),
  .standby_set_in(standby_set_in), .flag_clear_in(flag_clear_in),
  .rx_data_out(rx_data_out), .rx_buffer_full_flag_out(rx_buffer_full_flag_out),
  .frame_error_flag_out(frame_error_flag_out), .noise_flag_out(noise_flag_out),
  .idle_flag_out(idle_flag_out), .rx_standby_bit_out(rx_standby_bit_out),
  .rx_irq_out(rx_irq_out));
